/* File: verilog/plsc_params.svh */
// Constants for the PHY link setup control block
`ifndef PLSC_PARAMS_SVH
`define PLSC_PARAMS_SVH
`define PLSC_ADDR_W 8
`define PLSC_OFF_CTRL1 8'h00
`define PLSC_OFF_CTRL2 8'h04
`define PLSC_OFF_ADV1 8'h08
`define PLSC_OFF_ADV2 8'h0C
`define PLSC_OFF_STAT1 8'h10
`define PLSC_OFF_STAT2 8'h14
`define PLSC_BIT_AN_EN 0
`define PLSC_BIT_RESTART 1
`define PLSC_BIT_ROLE 2
`define PLSC_BIT_ABL 0
`define PLSC_BIT_REQ 1
`define PLSC_RST_AN_EN 1'b1
`define PLSC_RST_ROLE1 1'b1
`define PLSC_RST_ROLE2 1'b0
`define PLSC_RESP_OKAY 2'b00
`define PLSC_RESP_SLVERR 2'b10
`define PLSC_AN_TIME_US 20
`define PLSC_CLK_MHZ 20
`define PLSC_AN_CYCLES (`PLSC_AN_TIME_US * `PLSC_CLK_MHZ)
`endif

/* File: verilog/plsc_pkg.sv */
// Types shared by the PHY link setup control block
`default_nettype none
package plsc_pkg;
    typedef enum logic [1:0] {
        PLSC_AN_IDLE = 2'b00,
        PLSC_AN_BUSY = 2'b01,
        PLSC_AN_DONE = 2'b10
    } plsc_an_state_t;
endpackage
`default_nettype wire

/* File: verilog/plsc_port.sv */
// One port's negotiation engine: arbitration of amplitude and role
`timescale 1ns/1ps
`default_nettype none
`include "plsc_params.svh"
module plsc_port (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration
    input wire logic an_enable,
    input wire logic restart_pulse,
    input wire logic role_preference_bit,
    input wire logic local_high_level_ability_bit,
    input wire logic local_high_level_request_bit,
    input wire logic high_mode,
    // Link partner results
    input wire logic partner_pages_valid,
    input wire logic partner_ability,
    input wire logic partner_request,
    input wire logic partner_prefers_leader,
    input wire logic link_up,
    // Outcome
    output logic an_complete,
    output logic leader,
    output logic tx_high_level,
    output logic an_busy
);
    plsc_pkg::plsc_an_state_t state_r, state_nxt;
    logic [9:0] timer_r;
    logic link_d_r;
    logic link_lost;
    logic hi_res;
    logic leader_res;

    assign link_lost = link_d_r && !link_up;
    // Both able and at least one asks; pin gates local ability
    assign hi_res = high_mode && local_high_level_ability_bit && partner_ability
                    && (local_high_level_request_bit || partner_request);
    // Any tie makes this side lead; otherwise the partner's preference decides
    assign leader_res = role_preference_bit || !partner_prefers_leader;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            plsc_pkg::PLSC_AN_IDLE: if (an_enable) state_nxt = plsc_pkg::PLSC_AN_BUSY;
            plsc_pkg::PLSC_AN_BUSY: begin
                if (!an_enable) begin
                    state_nxt = plsc_pkg::PLSC_AN_IDLE;
                end else if (partner_pages_valid && timer_r == 10'(`PLSC_AN_CYCLES - 1)) begin
                    state_nxt = plsc_pkg::PLSC_AN_DONE;
                end
            end
            plsc_pkg::PLSC_AN_DONE: begin
                if (!an_enable) state_nxt = plsc_pkg::PLSC_AN_IDLE;
                else if (link_lost || restart_pulse) state_nxt = plsc_pkg::PLSC_AN_BUSY;
            end
            default: state_nxt = plsc_pkg::PLSC_AN_IDLE;
        endcase
        if (an_enable && restart_pulse) state_nxt = plsc_pkg::PLSC_AN_BUSY;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state_r <= plsc_pkg::PLSC_AN_IDLE;
        else state_r <= state_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_nxt != plsc_pkg::PLSC_AN_BUSY || state_r != state_nxt) begin
            timer_r <= 10'h000;
        end else if (timer_r != 10'(`PLSC_AN_CYCLES - 1)) begin
            timer_r <= timer_r + 10'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) link_d_r <= 1'b0;
        else link_d_r <= link_up;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leader <= `PLSC_RST_ROLE2;
            tx_high_level <= 1'b0;
        end else if (!an_enable) begin
            leader <= role_preference_bit;
            tx_high_level <= high_mode && local_high_level_ability_bit;
        end else if (state_r == plsc_pkg::PLSC_AN_BUSY && state_nxt == plsc_pkg::PLSC_AN_DONE) begin
            leader <= leader_res;
            tx_high_level <= hi_res;
        end
    end

    assign an_complete = state_r == plsc_pkg::PLSC_AN_DONE;
    assign an_busy = state_r == plsc_pkg::PLSC_AN_BUSY;

    // Disabled negotiation follows the role bit
    role_forced_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !an_enable |=> leader == $past(role_preference_bit))
        else $error("forced role not applied");
    // On completion the amplitude equals the arbitration result
    level_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(an_complete) |-> tx_high_level == $past(hi_res))
        else $error("resolved level wrong");
    // Link loss restarts within one cycle
    loss_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (an_complete && an_enable && link_lost) |=> an_busy)
        else $error("no restart on link loss");
    restart_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (an_enable && restart_pulse) |=> an_busy)
        else $error("restart not taken");
    cover_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(an_complete));
    cover_hi: cover property (@(posedge aclk) disable iff (!aresetn) $rose(tx_high_level));
endmodule
`default_nettype wire

/* File: verilog/plsc_top.sv */
// Two-port link setup control with AXI4-Lite register access
// What this block does
// - Amplitude mode per port from its pin
// - Floating pin, pulled low, means high mode
// - Pin level loads advertisement defaults
// - High mode: negotiation sets operating amplitude
// - Role bit forces the role when negotiation disabled, else gives our preference
// - Role bit: 0 follower, 1 leader
// - Reset roles: port1 leader, port2 follower
// - Role tie: this side becomes leader
// - Pages exchanged, arbitration elects mode and role
// - Link loss restarts negotiation automatically
// - Restart bit write restarts a completed negotiation; one in progress keeps its timer running
// - Negotiation enabled out of reset
// - Ability bit: 0 low only, 1 both
// - Negotiated high level needs both able, one requesting
`timescale 1ns/1ps
`default_nettype none
`include "plsc_params.svh"
module plsc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [`PLSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [`PLSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Hardware configuration pins (active high = 1.0 V only)
    input wire logic port1_high_amplitude_pin,
    input wire logic port2_high_amplitude_pin,
    // Link partner results per port
    input wire logic [1:0] partner_pages_valid,
    input wire logic [1:0] partner_ability,
    input wire logic [1:0] partner_request,
    input wire logic [1:0] partner_prefers_leader,
    input wire logic [1:0] link_up,
    // Per-port outcome
    output logic [1:0] high_mode,
    output logic [1:0] leader,
    output logic [1:0] tx_high_level,
    output logic [1:0] an_complete
);
    logic [1:0] an_en_r, role_r, abl_r, req_r, restart_r, high_mode_r, strap_done_r;
    logic [1:0] pins, an_busy;
    logic [`PLSC_ADDR_W-1:0] awaddr_r;
    logic aw_held_r, w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic [2:0] wr_dec;

    assign pins = {port2_high_amplitude_pin, port1_high_amplitude_pin};

    function automatic logic [2:0] decode_port(input logic [`PLSC_ADDR_W-1:0] a);
        // {valid, is_adv, port}
        logic [2:0] r;
        r = 3'b000;
        unique case (a)
            `PLSC_OFF_CTRL1: r = 3'b100;
            `PLSC_OFF_CTRL2: r = 3'b101;
            `PLSC_OFF_ADV1: r = 3'b110;
            `PLSC_OFF_ADV2: r = 3'b111;
            default: r = 3'b000;
        endcase
        return r;
    endfunction

    // Write channel: address and data accepted independently
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    // Held address decoded once for the response code
    assign wr_dec = decode_port(awaddr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PLSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_dec[2] ? `PLSC_RESP_OKAY : `PLSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Pin strap captured at the first clocked cycle after reset release
    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            logic [2:0] dec;
            logic hit;
            assign dec = decode_port(awaddr_r);
            assign hit = do_write && dec[2] && dec[0] == 1'(p) && wstrb_r[0];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    strap_done_r[p] <= 1'b0;
                    high_mode_r[p] <= 1'b1;
                end else if (!strap_done_r[p]) begin
                    strap_done_r[p] <= 1'b1;
                    high_mode_r[p] <= !pins[p];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    an_en_r[p] <= `PLSC_RST_AN_EN;
                    role_r[p] <= (p == 0) ? `PLSC_RST_ROLE1 : `PLSC_RST_ROLE2;
                end else if (hit && !dec[1]) begin
                    an_en_r[p] <= wdata_r[`PLSC_BIT_AN_EN];
                    role_r[p] <= wdata_r[`PLSC_BIT_ROLE];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) restart_r[p] <= 1'b0;
                else restart_r[p] <= hit && !dec[1] && wdata_r[`PLSC_BIT_RESTART];
            end

            // Software can only lower advertisement below what the pin allows
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    abl_r[p] <= 1'b0;
                    req_r[p] <= 1'b0;
                end else if (!strap_done_r[p]) begin
                    abl_r[p] <= !pins[p];
                    req_r[p] <= 1'b0;
                end else if (hit && dec[1]) begin
                    abl_r[p] <= wdata_r[`PLSC_BIT_ABL] && high_mode_r[p];
                    req_r[p] <= wdata_r[`PLSC_BIT_REQ] && high_mode_r[p];
                end
            end

            // Strap is taken once and then holds until the next reset
            strap_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
                strap_done_r[p] && $past(strap_done_r[p]) |-> $stable(high_mode_r[p]))
                else $error("strap level changed");

            // Defaults follow the pin: ability from the strap, no request
            adv_default_a: assert property (@(posedge aclk) disable iff (!aresetn)
                $rose(strap_done_r[p]) |-> abl_r[p] == high_mode_r[p] && !req_r[p])
                else $error("advertisement default wrong");

            // Low level strap caps both advertisement bits at zero
            adv_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
                strap_done_r[p] && !high_mode_r[p] |-> !abl_r[p] && !req_r[p])
                else $error("advertisement above strap");

            // A restart write yields a single pulse
            restart_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
                restart_r[p] |=> !restart_r[p])
                else $error("restart pulse too long");

            // Negotiation off: level is strap and ability, one cycle later
            forced_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
                strap_done_r[p] && !an_en_r[p]
                    |=> tx_high_level[p] == $past(high_mode_r[p] && abl_r[p]))
                else $error("forced level wrong");

            // Engine waits for the strap so its first advertisement is right
            plsc_port u_port (
                .aclk(aclk),
                .aresetn(aresetn && strap_done_r[p]),
                .an_enable(an_en_r[p]),
                .restart_pulse(restart_r[p]),
                .role_preference_bit(role_r[p]),
                .local_high_level_ability_bit(abl_r[p]),
                .local_high_level_request_bit(req_r[p]),
                .high_mode(high_mode_r[p]),
                .partner_pages_valid(partner_pages_valid[p]),
                .partner_ability(partner_ability[p]),
                .partner_request(partner_request[p]),
                .partner_prefers_leader(partner_prefers_leader[p]),
                .link_up(link_up[p]),
                .an_complete(an_complete[p]),
                .leader(leader[p]),
                .tx_high_level(tx_high_level[p]),
                .an_busy(an_busy[p])
            );
        end
    endgenerate

    assign high_mode = high_mode_r;

    // Read channel: one-cycle answer after address accepted
    // Offsets outside the map answer with an error rather than hang the master
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PLSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PLSC_RESP_OKAY;
            unique case (s_axi_araddr)
                `PLSC_OFF_CTRL1: s_axi_rdata <= {29'h0, role_r[0], 1'b0, an_en_r[0]};
                `PLSC_OFF_CTRL2: s_axi_rdata <= {29'h0, role_r[1], 1'b0, an_en_r[1]};
                `PLSC_OFF_ADV1: s_axi_rdata <= {30'h0, req_r[0], abl_r[0]};
                `PLSC_OFF_ADV2: s_axi_rdata <= {30'h0, req_r[1], abl_r[1]};
                `PLSC_OFF_STAT1: s_axi_rdata <= {27'h0, an_busy[0], high_mode_r[0],
                                                 tx_high_level[0], leader[0], an_complete[0]};
                `PLSC_OFF_STAT2: s_axi_rdata <= {27'h0, an_busy[1], high_mode_r[1],
                                                 tx_high_level[1], leader[1], an_complete[1]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PLSC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Defaults after reset
    reset_roles_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> role_r == 2'b01 && an_en_r == 2'b11)
        else $error("reset defaults wrong");
    strap_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(strap_done_r[0]) |-> high_mode_r[0] == !$past(pins[0]))
        else $error("pin strap not applied");
    strap_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(strap_done_r[1]) |-> abl_r[1] == high_mode_r[1])
        else $error("advertisement default wrong");
    adv_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !high_mode_r[0] && strap_done_r[0] |-> !abl_r[0] && !tx_high_level[0])
        else $error("high level without high mode");
    one_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write not answered");

    // Read answer one cycle after the address
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");

    // Offsets above the map read as zero with an error
    unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr > `PLSC_OFF_STAT2
        |=> s_axi_rresp == `PLSC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read answered");

    // A write to an unmapped offset changes no control
    unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && !wr_dec[2] |=> $stable(an_en_r) && $stable(role_r) && $stable(abl_r)
        && $stable(req_r))
        else $error("unmapped write took effect");

    // Port 1 engine stays idle until its strap is known
    engine_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !strap_done_r[0] |-> !an_complete[0] && !leader[0] && !tx_high_level[0])
        else $error("engine ran before strap");
    cover_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
    cover_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid);
    cover_restart: cover property (@(posedge aclk) disable iff (!aresetn) |restart_r);
    cover_forced: cover property (@(posedge aclk) disable iff (!aresetn)
        strap_done_r[0] && !an_en_r[0]);
endmodule
`default_nettype wire

/* File: tb/plsc_link_partner.sv */
// Behavioural remote link partner serving both ports
`timescale 1ns/1ps
`default_nettype none
module plsc_link_partner (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench commands
    input wire logic [1:0] present,
    input wire logic [1:0] adv_ability,
    input wire logic [1:0] adv_request,
    input wire logic [1:0] adv_leader,
    input wire logic [7:0] page_delay,
    // Toward the block
    output logic [1:0] partner_pages_valid,
    output logic [1:0] partner_ability,
    output logic [1:0] partner_request,
    output logic [1:0] partner_prefers_leader,
    output logic [1:0] link_up
);
    logic [7:0] cnt_r [2];

    // Pages arrive only after a settable exchange time, so slow partners can be modelled
    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!aresetn || !present[p]) begin
                cnt_r[p] <= 8'h00;
                partner_pages_valid[p] <= 1'h0;
            end else if (cnt_r[p] == page_delay) begin
                partner_pages_valid[p] <= 1'h1;
            end else begin
                cnt_r[p] <= cnt_r[p] + 8'h01;
            end
        end
    end

    // Without pages the fields carry no meaning, so show the inverse
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            partner_ability[p] = partner_pages_valid[p] ? adv_ability[p] : ~adv_ability[p];
            partner_request[p] = partner_pages_valid[p] ? adv_request[p] : ~adv_request[p];
            partner_prefers_leader[p] = partner_pages_valid[p] ? adv_leader[p] : ~adv_leader[p];
        end
    end

    assign link_up = partner_pages_valid & present;
endmodule
`default_nettype wire

/* File: tb/test_phy_link_setup_control.sv */
// Self-checking bench for the PHY link setup control block
`timescale 1ns/1ps
`default_nettype none
`include "plsc_params.svh"
module test_phy_link_setup_control;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [`PLSC_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, pin, present, ab, rq, ld, pv, pab, preq, plead, lup;
    logic [1:0] high_mode, leader, tx_high, an_complete;
    logic [7:0] page_delay;
    int n_fail = 0;
    int n_compared = 0;

    plsc_top plsc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port1_high_amplitude_pin(pin[0]),
        .port2_high_amplitude_pin(pin[1]), .partner_pages_valid(pv),
        .partner_ability(pab), .partner_request(preq), .partner_prefers_leader(plead),
        .link_up(lup), .high_mode(high_mode), .leader(leader), .tx_high_level(tx_high),
        .an_complete(an_complete));

    plsc_link_partner plsc_link_partner_i (.aclk(aclk), .aresetn(aresetn),
        .present(present), .adv_ability(ab), .adv_request(rq), .adv_leader(ld),
        .page_delay(page_delay), .partner_pages_valid(pv), .partner_ability(pab),
        .partner_request(preq), .partner_prefers_leader(plead), .link_up(lup));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are judged on the falling edge, where they equal the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] exp);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b_hs = 1'h0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'h0;
            if (w_hs) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        chk({30'h0, r}, {30'h0, exp});
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_hs, r_hs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r_hs = 1'h0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask

    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        for (int i = 0; i < 300; i++) begin
            rd(a);
            if ((d & m) === exp) break;
        end
        chk(d & m, exp);
    endtask

    task automatic t_reset;
        // Strap lands at the first edge after release
        repeat (2) @(negedge aclk);
        chk({30'h0, high_mode}, 32'h0000_0001);
        rd(`PLSC_OFF_CTRL1);
        chk(d, 32'h0000_0005);
        rd(`PLSC_OFF_CTRL2);
        chk(d, 32'h0000_0001);
        rd(`PLSC_OFF_ADV1);
        chk(d, 32'h0000_0001);
        rd(`PLSC_OFF_ADV2);
        chk(d, 32'h0000_0000);
    endtask

    task automatic t_negotiate;
        poll(`PLSC_OFF_STAT1, 32'h0000_001F, 32'h0000_000F);
        poll(`PLSC_OFF_STAT2, 32'h0000_001F, 32'h0000_0001);
        chk({30'h0, leader}, 32'h0000_0001);
        chk({30'h0, tx_high}, 32'h0000_0001);
        chk({30'h0, an_complete}, 32'h0000_0003);
    endtask

    task automatic t_link_loss;
        @(posedge aclk);
        present <= 2'h2;
        poll(`PLSC_OFF_STAT1, 32'h0000_0011, 32'h0000_0010);
        @(posedge aclk);
        present <= 2'h3;
        poll(`PLSC_OFF_STAT1, 32'h0000_001F, 32'h0000_000F);
    endtask

    // Partner request, local advertisement, expected status after a restart
    task automatic t_restart;
        logic [31:0] adv [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0002};
        logic [31:0] st [3] = '{32'h0000_000B, 32'h0000_000F, 32'h0000_000B};
        logic [1:0] prq [3] = '{2'h2, 2'h2, 2'h3};
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            rq <= prq[k];
            wr(`PLSC_OFF_ADV1, adv[k], `PLSC_RESP_OKAY);
            wr(`PLSC_OFF_CTRL1, 32'h0000_0007, `PLSC_RESP_OKAY);
            poll(`PLSC_OFF_STAT1, 32'h0000_0011, 32'h0000_0010);
            poll(`PLSC_OFF_STAT1, 32'h0000_001F, st[k]);
        end
    endtask

    task automatic t_forced_role;
        wr(`PLSC_OFF_CTRL1, 32'h0000_0000, `PLSC_RESP_OKAY);
        poll(`PLSC_OFF_STAT1, 32'h0000_0002, 32'h0000_0000);
        wr(`PLSC_OFF_CTRL2, 32'h0000_0004, `PLSC_RESP_OKAY);
        poll(`PLSC_OFF_STAT2, 32'h0000_0002, 32'h0000_0002);
        chk({30'h0, leader}, 32'h0000_0002);
    endtask

    task automatic t_unmapped;
        wr(8'h40, 32'h0000_0007, `PLSC_RESP_SLVERR);
        rd(8'h40);
        chk(d, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, `PLSC_RESP_SLVERR});
    endtask

    // Second reset with straps swapped: port 1 low level only, port 2 high
    task automatic t_strap_swap;
        @(posedge aclk);
        aresetn <= 1'h0;
        pin <= 2'h1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(negedge aclk);
        chk({30'h0, high_mode}, 32'h0000_0002);
        rd(`PLSC_OFF_ADV1);
        chk(d, 32'h0000_0000);
        rd(`PLSC_OFF_ADV2);
        chk(d, 32'h0000_0001);
        wr(`PLSC_OFF_ADV1, 32'h0000_0003, `PLSC_RESP_OKAY);
        rd(`PLSC_OFF_ADV1);
        chk(d, 32'h0000_0000);
        poll(`PLSC_OFF_STAT1, 32'h0000_001F, 32'h0000_0003);
        poll(`PLSC_OFF_STAT2, 32'h0000_001F, 32'h0000_000D);
        chk({30'h0, an_complete}, 32'h0000_0003);
    endtask

    task automatic stop_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    // Restarts take some 400 cycles each; this bound covers all of them with margin
    initial begin
        #(50 * 30000);
        n_fail++;
        stop_test();
    end

    initial begin
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        pin = 2'h2;
        present = 2'h3;
        ab = 2'h3;
        rq = 2'h3;
        ld = 2'h2;
        page_delay = 8'h1E;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_negotiate();
        t_link_loss();
        t_restart();
        t_forced_role();
        t_unmapped();
        t_strap_swap();
        stop_test();
    end
endmodule
`default_nettype wire
